/* File: verilog/lsf_pkg.sv */
// shared constants and types for the link status, frequency and pin block
package lsf_pkg;

    // register indices; byte address on the bus is four times the index
    localparam logic [7:0] IDX_FREQ_COUNT = 8'h1b;
    localparam logic [7:0] IDX_GEN_STATUS = 8'h1c;
    localparam logic [7:0] IDX_PIN0_CFG   = 8'h1d;

    // reset values and counter saturation limit
    localparam logic [7:0] FREQ_RST        = 8'h00;
    localparam logic [1:0] PIN0_HIGH_RST   = 2'b00;
    localparam logic [7:0] SAT_MAX         = 8'hff;

    // general status field positions
    localparam int ST_TX_TWO_LANE = 5;
    localparam int ST_RX_TWO_LANE = 4;
    localparam int ST_AUDIO_LOCK  = 3;
    localparam int ST_SIG_DETECT  = 1;
    localparam int ST_CDR_LOCK    = 0;

    // pin zero configuration field positions
    localparam int PC_REV_LSB   = 4;
    localparam int PC_LOCAL_LVL = 3;
    localparam int PC_FAR_CTL   = 2;
    localparam int PC_DIR_BIT   = 1;
    localparam int PC_FUNC_BIT  = 0;

    // timing: window unit is one oscillator period, mclk runs at 100 MHz
    localparam int OSC_PERIOD_NS = 50;
    localparam int CLK_PERIOD_NS = 10;
    localparam int CYC_PER_OSC   = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // pad modes decoded from {direction, function} bits
    typedef enum logic [1:0] {
        PM_FUNC_OUT,
        PM_TRISTATE,
        PM_GP_OUT,
        PM_GP_IN
    } lsf_pin_mode_e;

endpackage

/* File: verilog/lsf_edge_count.sv */
// pixel clock edge sampler with saturating edge counter
`timescale 1ns/1ps
`default_nettype none

module lsf_edge_count
    import lsf_pkg::*;
#(
    parameter int CNT_W = 8
)
(
    input  wire logic             mclk,
    input  wire logic             srst,
    input  wire logic             ce,
    input  wire logic             pixClk,
    input  wire logic             clear,
    input  wire logic             countEn,
    output logic [CNT_W-1:0]      count
);

    generate
        if (CNT_W < 1 || CNT_W > 8)
        begin : g_chk
            $error("lsf_edge_count: CNT_W must be 1 to 8");
        end
    endgenerate

    typedef struct packed {
        logic [2:0]       samp;
        logic [CNT_W-1:0] cnt;
    } lsf_cnt_state_s;

    lsf_cnt_state_s q;
    lsf_cnt_state_s d;
    logic           risingEdge;
    logic [CNT_W-1:0] satMax;

    // stage 0 feeds only stage 1; edges are seen between stages 1 and 2
    assign risingEdge = q.samp[1] && !q.samp[2];
    assign satMax     = SAT_MAX[CNT_W-1:0];

    ///////////////////////////////////////////////////////////////////////////
    // next state: sampling chain and saturating count
    always_comb
    begin
        d = q;
        if (ce)
        begin
            d.samp = {q.samp[1:0], pixClk};
            if (clear)
            begin
                d.cnt = '0;
            end
            else if (countEn && risingEdge && q.cnt != satMax)
            begin
                d.cnt = q.cnt + 1'b1;  // holds at the top, never wraps
            end
        end
        if (srst)
        begin
            d.samp = 3'b000;
            d.cnt  = '0;
        end
    end

    // one register for the whole state
    always_ff @(posedge mclk)
    begin
        q <= d;
    end

    assign count = q.cnt;

    ///////////////////////////////////////////////////////////////////////////
    // checks
    cnt_saturate_a : assert property (
        @(posedge mclk) disable iff (srst || !ce)
        q.cnt == satMax && !clear |=> q.cnt == satMax)
        else $error("edge counter left its saturated value");

    cnt_clear_a : assert property (
        @(posedge mclk) disable iff (srst || !ce)
        clear |=> q.cnt == '0)
        else $error("edge counter not cleared at window start");

endmodule

`default_nettype wire

/* File: verilog/lsf_link_status_regs.sv */
// register bank: pixel frequency counter, link status and pin zero setup
//
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - writing the frequency register opens a window of value times oscillator periods
// - reading the frequency register returns edges counted in the latest window
// - status bit 5 shows transmit dual-link (1) or single-link (0)
// - status bit 4 shows receive dual-link (1) or single-link (0)
// - status bit 3 shows audio PLL locked to incoming audio clock
// - status bit 1 shows serial input detected on receive port
// - status bit 0 shows CDR lock; in dual-link both channels must lock
// - local level drives pin only in general output mode without far control
// - far control set makes the pin an output carrying the remote value
// - direction/function pair: 00 functional, 10 tristate, 01 gp output, 11 gp input
// - direction and function bits reset to 1 when second port is selected
// - with second port selected, the setup steers the second port pin
module lsf_link_status_regs
    import lsf_pkg::*;
#(
    parameter int         ADR_W        = 8,
    parameter logic [3:0] SILICON_REV  = 4'h7   // arbitrary revision value
)
(
    input  wire logic             mclk,
    input  wire logic             srst,
    input  wire logic             ce,
    input  wire logic             wbCyc,
    input  wire logic             wbStb,
    input  wire logic             wbWe,
    input  wire logic [ADR_W-1:0] wbAdr,
    input  wire logic [3:0]       wbSel,
    input  wire logic [31:0]      wbDatW,
    output logic      [31:0]      wbDatR,
    output logic                  wbAck,
    input  wire logic             pixClk,
    input  wire logic             txTwoLaneActive,
    input  wire logic             rxTwoLaneActive,
    input  wire logic             audioPllLocked,
    input  wire logic             serialDetect,
    input  wire logic             cdrLockPrimary,
    input  wire logic             cdrLockSecond,
    input  wire logic             secondPortSelect,
    input  wire logic             funcLevel0,
    input  wire logic             farLevel0,
    input  wire logic             pin0In,
    output logic                  pin0Out,
    output logic                  pin0Oe,
    input  wire logic             secondPortPin0In,
    output logic                  secondPortPin0Out,
    output logic                  secondPortPin0Oe,
    output logic                  pin0SensedLevel,
    output logic                  windowBusy
);

    localparam int WT_W = 12;

    generate
        if (ADR_W < 7 || ADR_W > 32)
        begin : g_chk
            $error("lsf_link_status_regs: ADR_W must be 7 to 32");
        end
        if (255 * CYC_PER_OSC >= (1 << WT_W))
        begin : g_chk_wt
            $error("lsf_link_status_regs: window timer too narrow");
        end
    endgenerate

    ///////////////////////////////////////////////////////////////////////////
    // decoding helpers

    // word index match for a register index on the byte address bus
    function automatic logic regHit(input logic [ADR_W-1:0] adr, input logic [7:0] idx);
        logic [ADR_W-1:0] base;
        base = ADR_W'({idx, 2'b00});
        return adr[ADR_W-1:2] == base[ADR_W-1:2];
    endfunction

    // pad mode from {direction, function}
    function automatic lsf_pin_mode_e pinMode(input logic dirBit, input logic funcBit);
        lsf_pin_mode_e m;
        unique case ({dirBit, funcBit})
            2'b00: m = PM_FUNC_OUT;
            2'b10: m = PM_TRISTATE;
            2'b01: m = PM_GP_OUT;
            2'b11: m = PM_GP_IN;
        endcase
        return m;
    endfunction

    ///////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic            ack;
        logic [7:0]      rdData;
        logic            winOpen;
        logic [WT_W-1:0] winTimer;
        logic [3:0]      pinCfg;      // local level, far control, direction, function
        logic [1:0]      padOut;      // index 0 primary pin, 1 second port pin
        logic [1:0]      padOe;
        logic            sensed;
    } lsf_reg_state_s;

    lsf_reg_state_s q;
    lsf_reg_state_s d;

    logic          busReq;
    logic          accept;
    logic          wrFreq;
    logic          wrPin;
    logic [7:0]    edgeCount;
    logic [7:0]    statusByte;
    logic          cdrLocked;
    lsf_pin_mode_e selMode;
    logic [1:0]    drvOut;
    logic [1:0]    drvOe;
    logic [1:0]    padIn;

    // a request is served once; ack drops the cycle after it is given
    assign busReq = wbCyc && wbStb;
    assign accept = ce && busReq && !q.ack;
    assign wrFreq = accept && wbWe && wbSel[0] && regHit(wbAdr, IDX_FREQ_COUNT);
    assign wrPin  = accept && wbWe && wbSel[0] && regHit(wbAdr, IDX_PIN0_CFG);

    ///////////////////////////////////////////////////////////////////////////
    // pixel edge counting, crossed in by sampling before any edge logic

    lsf_edge_count #(
        .CNT_W   (8)
    ) u_edge_count (
        .mclk    (mclk),
        .srst    (srst),
        .ce      (ce),
        .pixClk  (pixClk),
        .clear   (wrFreq),
        .countEn (q.winOpen),
        .count   (edgeCount)
    );

    ///////////////////////////////////////////////////////////////////////////
    // status byte, reserved bits tied low

    // in dual-link reception both channels must report lock
    assign cdrLocked = rxTwoLaneActive ? (cdrLockPrimary && cdrLockSecond)
                                       : cdrLockPrimary;

    always_comb
    begin
        statusByte                 = 8'h00;
        statusByte[ST_TX_TWO_LANE] = txTwoLaneActive;
        statusByte[ST_RX_TWO_LANE] = rxTwoLaneActive;
        statusByte[ST_AUDIO_LOCK]  = audioPllLocked;
        statusByte[ST_SIG_DETECT]  = serialDetect;
        statusByte[ST_CDR_LOCK]    = cdrLocked;
    end

    ///////////////////////////////////////////////////////////////////////////
    // pad drive for both pins; only the selected pin takes the setup

    assign selMode = pinMode(q.pinCfg[PC_DIR_BIT], q.pinCfg[PC_FUNC_BIT]);
    assign padIn   = {secondPortPin0In, pin0In};

    generate
        for (genvar i = 0; i < 2; i++)
        begin : g_pad
            logic chosen;
            lsf_pin_mode_e mode;
            assign chosen = (i == 1) == secondPortSelect;
            assign mode   = pinMode(q.pinCfg[PC_DIR_BIT], q.pinCfg[PC_FUNC_BIT]);
            always_comb
            begin
                drvOut[i] = 1'b0;
                drvOe[i]  = 1'b0;
                if (chosen && q.pinCfg[PC_FAR_CTL])
                begin
                    drvOut[i] = farLevel0;
                    drvOe[i]  = 1'b1;
                end
                else if (chosen)
                begin
                    unique case (mode)
                        PM_FUNC_OUT:
                        begin
                            drvOut[i] = funcLevel0;
                            drvOe[i]  = 1'b1;
                        end
                        PM_GP_OUT:
                        begin
                            drvOut[i] = q.pinCfg[PC_LOCAL_LVL];
                            drvOe[i]  = 1'b1;
                        end
                        PM_TRISTATE, PM_GP_IN:
                        begin
                            drvOut[i] = 1'b0;  // pad released
                            drvOe[i]  = 1'b0;
                        end
                    endcase
                end
            end
        end
    endgenerate

    ///////////////////////////////////////////////////////////////////////////
    // next state: bus slave, window timer, pin setup and pad registers
    // reset wins over a low clock enable so straps are always caught
    always_comb
    begin
        d     = q;
        d.ack = 1'b0;
        if (ce)
        begin
            d.ack = busReq && !q.ack;
            if (accept)
            begin
                d.rdData = 8'h00;  // unmapped words answer with zero
                if (regHit(wbAdr, IDX_FREQ_COUNT))
                begin
                    d.rdData = edgeCount;
                end
                else if (regHit(wbAdr, IDX_GEN_STATUS))
                begin
                    d.rdData = statusByte;
                end
                else if (regHit(wbAdr, IDX_PIN0_CFG))
                begin
                    d.rdData = {SILICON_REV, q.pinCfg};
                end
            end
            // window: a new write restarts it, a zero write closes it
            if (wrFreq)
            begin
                d.winTimer = WT_W'(wbDatW[7:0] * CYC_PER_OSC);
                d.winOpen  = wbDatW[7:0] != 8'h00;
            end
            else if (q.winOpen)
            begin
                d.winTimer = q.winTimer - 1'b1;
                d.winOpen  = q.winTimer != WT_W'(1);
            end
            // only the low nibble is writable; revision field ignores writes
            if (wrPin)
            begin
                d.pinCfg = wbDatW[3:0];
            end
            d.padOut = drvOut;
            d.padOe  = drvOe;
            d.sensed = secondPortSelect ? padIn[1] : padIn[0];
        end
        if (srst)
        begin
            d.ack      = 1'b0;
            d.rdData   = FREQ_RST;
            d.winOpen  = 1'b0;
            d.winTimer = '0;
            d.pinCfg   = {PIN0_HIGH_RST, secondPortSelect, secondPortSelect};
            d.padOut   = 2'b00;
            d.padOe    = 2'b00;
            d.sensed   = 1'b0;
        end
    end

    // one register for the whole state
    always_ff @(posedge mclk)
    begin
        q <= d;
    end

    ///////////////////////////////////////////////////////////////////////////
    // outputs

    assign wbAck             = q.ack;
    assign wbDatR            = {24'h000000, q.rdData};
    assign pin0Out           = q.padOut[0];
    assign pin0Oe            = q.padOe[0];
    assign secondPortPin0Out = q.padOut[1];
    assign secondPortPin0Oe  = q.padOe[1];
    assign pin0SensedLevel   = q.sensed;
    assign windowBusy        = q.winOpen;

    ///////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst || !ce);

    logic rdReq;
    assign rdReq = accept && !wbWe;

    win_length_a : assert property (
        wrFreq && wbDatW[7:0] == 8'h01 |=> q.winOpen [*5] ##1 !q.winOpen)
        else $error("one-unit window did not last five cycles");

    win_step_a : assert property (
        q.winOpen && !wrFreq && q.winTimer > WT_W'(1)
        |=> q.winOpen && q.winTimer == $past(q.winTimer) - 1'b1)
        else $error("window timer did not step down");

    rd_freq_a : assert property (
        rdReq && regHit(wbAdr, IDX_FREQ_COUNT) |=> wbAck && wbDatR[7:0] == $past(edgeCount))
        else $error("frequency read returned wrong count");

    status_tx_a : assert property (
        rdReq && regHit(wbAdr, IDX_GEN_STATUS) |=> wbDatR[5] == $past(txTwoLaneActive))
        else $error("transmit lane status wrong");

    status_rx_a : assert property (
        rdReq && regHit(wbAdr, IDX_GEN_STATUS) |=> wbDatR[4] == $past(rxTwoLaneActive))
        else $error("receive lane status wrong");

    audio_lock_a : assert property (
        rdReq && regHit(wbAdr, IDX_GEN_STATUS) |=> wbDatR[3] == $past(audioPllLocked))
        else $error("audio lock status wrong");

    sig_detect_a : assert property (
        rdReq && regHit(wbAdr, IDX_GEN_STATUS) |=> wbDatR[1] == $past(serialDetect))
        else $error("signal detect status wrong");

    cdr_dual_a : assert property (
        rdReq && regHit(wbAdr, IDX_GEN_STATUS) && rxTwoLaneActive && !cdrLockSecond
        |=> wbDatR[0] == 1'b0 && wbDatR[7:6] == 2'b00 && wbDatR[2] == 1'b0)
        else $error("lock shown with one dual channel unlocked");

    gp_out_a : assert property (
        !secondPortSelect && selMode == PM_GP_OUT && !q.pinCfg[PC_FAR_CTL]
        |=> pin0Oe && pin0Out == $past(q.pinCfg[PC_LOCAL_LVL]))
        else $error("local level not driven in output mode");

    far_ctl_a : assert property (
        !secondPortSelect && q.pinCfg[PC_FAR_CTL] |=> pin0Oe && pin0Out == $past(farLevel0))
        else $error("far level not driven under remote control");

    tri_in_a : assert property (
        !q.pinCfg[PC_FAR_CTL] && q.pinCfg[PC_DIR_BIT] |=> !pin0Oe && !secondPortPin0Oe)
        else $error("pad driven while released or input");

    port_route_a : assert property (
        secondPortSelect |=> !pin0Oe)
        else $error("primary pin driven while second port selected");

    rev_ro_a : assert property (
        rdReq && regHit(wbAdr, IDX_PIN0_CFG) |=> wbDatR[7:4] == SILICON_REV)
        else $error("revision field changed");

    reset_cfg_a : assert property (
        @(posedge mclk) disable iff (1'b0)
        srst && secondPortSelect |=> q.pinCfg[1:0] == 2'b11)
        else $error("direction and function not reset high");

    cover_window_c : cover property (wrFreq ##1 q.winOpen [*3] ##1 edgeCount != 8'h00);
    cover_sat_c    : cover property (q.winOpen && edgeCount == SAT_MAX);
    cover_far_c    : cover property (q.pinCfg[PC_FAR_CTL] && secondPortPin0Oe);

endmodule

`default_nettype wire

/* File: test/lsf_far_model.sv */
// far-side model: remote serializer level for pin zero and pixel clock source
`timescale 1ns/1ps
`default_nettype none

module lsf_far_model
(
    input  wire logic       mclk,
    input  wire logic       pixRun,
    input  wire logic [3:0] pixHalf,
    input  wire logic       farBit,
    output logic            pixClk,
    output logic            farLevel0
);
    logic [3:0] phaseCnt;

    ////////////////////////////////////////////////////////////////////////////////
    // pixel clock stands low while not running, so no stray edges get counted
    always_ff @(posedge mclk)
    begin
        if (!pixRun)
        begin
            pixClk   <= 1'b0;
            phaseCnt <= 4'h1;
        end
        else if (phaseCnt >= pixHalf)
        begin
            pixClk   <= ~pixClk;
            phaseCnt <= 4'h1;
        end
        else
        begin
            phaseCnt <= phaseCnt + 4'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // remote level lands one cycle late, as a link hop would deliver it
    always_ff @(posedge mclk)
    begin
        farLevel0 <= farBit;
    end
endmodule

`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench for the link status, frequency and pin zero registers
`timescale 1ns/1ps
`default_nettype none

module testbench;
    import lsf_pkg::*;

    // arbitrary revision value, handed to the design instance below
    localparam logic [3:0] SILICON_REV_T = 4'h7;

    logic        mclk = 1'b0;
    logic        ce = 1'b1;
    logic        srst = 1'b1;
    logic        wbCyc = 1'b0;
    logic        wbStb = 1'b0;
    logic        wbWe = 1'b0;
    logic [7:0]  wbAdr = 8'h00;
    logic [3:0]  wbSel = 4'h0;
    logic [31:0] wbDatW = 32'h0;
    logic [31:0] wbDatR;
    logic        wbAck;
    logic [5:0]  stIn = 6'h00;
    logic        secondPortSelect = 1'b0;
    logic        funcLevel0 = 1'b0;
    logic        farBit = 1'b0;
    logic        pin0In = 1'b0;
    logic        secondPortPin0In = 1'b0;
    logic        pixRun = 1'b0;
    logic [3:0]  pixHalf = 4'h2;
    logic        pixClk, farLevel0, pin0Out, pin0Oe, sp0Out, sp0Oe, pin0SensedLevel, windowBusy;
    int          seed = 32'h7ff07788;
    int          mismatches = 0;
    int          num_checks = 0;
    logic [7:0]  q, n, exp8;
    logic [3:0]  h;
    logic [31:0] r;
    int          cnt;

    // free-running 100 MHz clock
    always #5 mclk = ~mclk;

    lsf_link_status_regs #(
        .SILICON_REV(SILICON_REV_T)
    ) u_lsf_link_status_regs (
        .mclk(mclk), .srst(srst), .ce(ce), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe),
        .wbAdr(wbAdr), .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck),
        .pixClk(pixClk), .txTwoLaneActive(stIn[5]), .rxTwoLaneActive(stIn[4]),
        .audioPllLocked(stIn[3]), .serialDetect(stIn[2]), .cdrLockPrimary(stIn[1]),
        .cdrLockSecond(stIn[0]), .secondPortSelect(secondPortSelect),
        .funcLevel0(funcLevel0), .farLevel0(farLevel0), .pin0In(pin0In), .pin0Out(pin0Out),
        .pin0Oe(pin0Oe), .secondPortPin0In(secondPortPin0In), .secondPortPin0Out(sp0Out),
        .secondPortPin0Oe(sp0Oe), .pin0SensedLevel(pin0SensedLevel), .windowBusy(windowBusy));

    lsf_far_model u_lsf_far_model (
        .mclk(mclk), .pixRun(pixRun), .pixHalf(pixHalf), .farBit(farBit),
        .pixClk(pixClk), .farLevel0(farLevel0));

    ////////////////////////////////////////////////////////////////////////////////
    // verdict and comparison
    task automatic stop_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one classic cycle; request held until ack is sampled, then released
    task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d,
                      input logic [3:0] sel, output logic [7:0] rd);
        int k;
        logic [31:0] junk;
        @(posedge mclk);
        junk = $random(seed);  // draws from the shared seed, so callers' later random draws shift
        wbCyc  <= 1'b1;
        wbStb  <= 1'b1;
        wbWe   <= we;
        wbAdr  <= {idx[5:0], 2'b00};
        wbSel  <= sel;
        wbDatW <= {junk[31:8], d};
        k = 0;
        do
        begin
            @(posedge mclk);
            k++;
        end
        while (wbAck !== 1'b1 && k < 20);
        rd = wbDatR[7:0];
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        chk(wbDatR[31:16] | {8'h00, wbDatR[15:8]}, 16'h0000);
        if (wbAck !== 1'b1)
        begin
            mismatches++;
            stop_test();
        end
    endtask

    task automatic rst(input logic sel);
        @(posedge mclk);
        srst             <= 1'b1;
        secondPortSelect <= sel;
        repeat (4) @(posedge mclk);
        srst <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // expectations; s is {tx, rx, audio, detect, lockPrimary, lockSecond}
    function automatic logic [7:0] expStatus(logic [5:0] s);
        return {2'b00, s[5], s[4], s[3], 1'b0, s[2], s[4] ? (s[1] & s[0]) : s[1]};
    endfunction

    function automatic logic [7:0] expCount(logic [7:0] w, logic [3:0] hh);
        int e;
        e = (int'(w) * CYC_PER_OSC) / (2 * int'(hh));
        return (e > 255) ? SAT_MAX : e[7:0];
    endfunction

    // sampling latency may shift one edge across the window end
    function automatic logic [7:0] fit(logic [7:0] seen, logic [7:0] exp);
        return (seen == exp + 8'h01 || seen + 8'h01 == exp) ? exp : seen;
    endfunction

    // one window: write, measure busy length, read back the count
    task automatic window(input logic [7:0] w, input logic [3:0] hh, input logic restart);
        @(posedge mclk);
        pixHalf <= hh;
        if (restart)
            wb(1'b1, IDX_FREQ_COUNT, 8'h28, 4'h1, q);
        wb(1'b1, IDX_FREQ_COUNT, w, 4'h1, q);
        cnt = 1;
        if (w == 8'h00)
            cnt = 0;
        while (windowBusy === 1'b1 && cnt < 1500)
        begin
            @(posedge mclk);
            if (windowBusy === 1'b1)
                cnt++;
        end
        chk(16'(cnt), 16'(int'(w) * CYC_PER_OSC));
        if (cnt >= 1500)
            stop_test();
        repeat (4) @(posedge mclk);
        wb(1'b0, IDX_FREQ_COUNT, 8'h00, 4'h1, q);
        chk({8'h00, fit(q, expCount(w, hh))}, {8'h00, expCount(w, hh)});
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        // reset values, both port selections
        rst(1'b0);
        wb(1'b0, IDX_FREQ_COUNT, 8'h00, 4'h1, q);
        chk({8'h00, q}, {8'h00, FREQ_RST});
        wb(1'b0, IDX_GEN_STATUS, 8'h00, 4'h1, q);
        chk({8'h00, q}, 16'h0000);
        wb(1'b0, IDX_PIN0_CFG, 8'h00, 4'h1, q);
        chk({8'h00, q}, {8'h00, SILICON_REV_T, 4'h0});
        rst(1'b1);
        wb(1'b0, IDX_PIN0_CFG, 8'h00, 4'h1, q);
        chk({8'h00, q}, {8'h00, SILICON_REV_T, 4'h3});
        chk({14'h0, sp0Oe, pin0Oe}, 16'h0000);
        // unmapped read, ignored writes
        wb(1'b0, 8'h1a, 8'h00, 4'h1, q);
        chk({8'h00, q}, 16'h0000);
        wb(1'b1, IDX_GEN_STATUS, 8'hff, 4'h1, q);
        wb(1'b0, IDX_GEN_STATUS, 8'h00, 4'h1, q);
        chk({8'h00, q}, 16'h0000);
        wb(1'b1, IDX_PIN0_CFG, 8'hf4, 4'h0, q);
        wb(1'b0, IDX_PIN0_CFG, 8'h00, 4'h1, q);
        chk({8'h00, q}, {8'h00, SILICON_REV_T, 4'h3});
        // status: corner of dual link with one channel unlocked, then random
        for (int i = 0; i < 20; i++)
        begin
            r = $random(seed);
            stIn <= (i == 0) ? 6'h12 : r[5:0];
            wb(1'b0, IDX_GEN_STATUS, 8'h00, 4'h1, q);
            chk({8'h00, q}, {8'h00, expStatus(stIn)});
        end
        // every mode, with and without far control, on both pads
        for (int i = 0; i < 16; i++)
        begin
            r = $random(seed);
            @(posedge mclk);
            secondPortSelect <= i[3];
            {funcLevel0, farBit, pin0In, secondPortPin0In} <= r[3:0];
            wb(1'b1, IDX_PIN0_CFG, {4'hf, r[4], i[2:0]}, 4'h1, q);
            wb(1'b0, IDX_PIN0_CFG, 8'h00, 4'h1, q);
            chk({8'h00, q}, {8'h00, SILICON_REV_T, r[4], i[2:0]});
            repeat (4) @(posedge mclk);
            exp8[1] = i[2] | ~i[1];
            exp8[0] = exp8[1] & (i[2] ? r[2] : (i[0] ? r[4] : r[3]));
            if (i[3])
                chk({12'h0, pin0Oe, sp0Oe, sp0Oe, sp0Oe & sp0Out}, {13'h0, exp8[1], exp8[1:0]});
            else
                chk({12'h0, sp0Oe, pin0Oe, pin0Oe, pin0Oe & pin0Out}, {13'h0, exp8[1], exp8[1:0]});
            chk({15'h0, pin0SensedLevel}, {15'h0, i[3] ? r[0] : r[1]});
        end
        // clock enable low freezes a one-unit window part way through
        wb(1'b1, IDX_FREQ_COUNT, 8'h01, 4'h1, q);
        ce <= 1'b0;
        repeat (20) @(posedge mclk);
        chk({15'h0, windowBusy}, 16'h0001);
        ce <= 1'b1;
        repeat (8) @(posedge mclk);
        chk({15'h0, windowBusy}, 16'h0000);
        // frequency windows: empty, saturating, restarted, random
        pixRun <= 1'b1;
        window(8'h00, 4'h3, 1'b0);
        window(8'hff, 4'h2, 1'b0);
        window(8'h02, 4'h2, 1'b1);
        for (int i = 0; i < 6; i++)
        begin
            r = $random(seed);
            n = 8'(1 + r[5:0] % 60);
            h = 4'(2 + r[9:8]);
            window(n, h, 1'b0);
        end
        stop_test();
    end
endmodule

`default_nettype wire
